// ---- rtl/spi_stop_pkg.sv ----
package spi_stop_pkg;

  // ==========================================================
  // Bus and field widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int DIV_W  = 8;
  localparam int CNT_W  = 9;
  localparam int NPINS  = 6;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DIV      = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_TXDATA   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_RXDATA   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_SEL = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_DIR = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_OUT = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_IN  = 4'h8;

  // ==========================================================
  // Pin positions in the pin vectors
  localparam int PIN_RCLK = 0;
  localparam int PIN_RFS  = 1;
  localparam int PIN_RDAT = 2;
  localparam int PIN_XCLK = 3;
  localparam int PIN_XFS  = 4;
  localparam int PIN_XDAT = 5;
  localparam logic [NPINS-1:0] INPUT_MASK  = 6'h1F;
  localparam logic [NPINS-1:0] OUTPUT_MASK = 6'h3B;

  // ==========================================================
  // Reset values and codes
  localparam logic [DIV_W-1:0] DIV_RESET  = 8'h01;
  localparam logic [NPINS-1:0] PINS_RESET = 6'h00;
  localparam logic [1:0]       STOP_LAUNCH_FALL_BIT = 2'h1;

  // Control register layout
  typedef struct packed {
    logic       sample_clock_source_select;
    logic       rx_sync_direction;
    logic       tx_sync_direction;
    logic       rx_clock_direction;
    logic       tx_clock_direction;
    logic       rx_sync_polarity;
    logic       tx_sync_polarity;
    logic       rx_clock_polarity;
    logic       tx_clock_polarity;
    logic [1:0] clock_stop_mode_field;
    logic       enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 12'h000;

  // Status register layout
  typedef struct packed {
    logic underrun;
    logic overrun;
    logic tx_empty;
    logic tx_ready;
    logic rx_full;
    logic busy;
  } status_t;

  // Master sequencer states
  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_LEAD  = 4'h2,
    M_SHIFT = 4'h4,
    M_TAIL  = 4'h8
  } mstate_t;

endpackage

// ---- rtl/serial_port_spi_clock_stop_mode.sv ----
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Word FIFO between register write and shifter
module tx_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,      // Core clock
  input  wire logic             rst_n_in,    // Async reset
  input  wire logic             wr_valid_in, // Word offered
  output logic                  wr_ready_out, // Room left
  input  wire logic [WIDTH-1:0] wr_data_in,  // Word in
  output logic                  rd_valid_out, // Word held
  input  wire logic             rd_ready_in, // Word taken
  output logic      [WIDTH-1:0] rd_data_out  // Head word
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             do_wr;
  logic             do_rd;

  // Handshakes
  assign wr_ready_out = (count != FULL_CNT);
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rd_ptr];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_ready_in & rd_valid_out;

  // Storage
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ============================================================
// Clock-stop serial port with pin reuse as general I/O
// Function
// (RQ1) GPIO inputs: clocks, syncs, receive data.
// (RQ2) GPIO outputs: all pins except receive data.
// (RQ3) GPIO updates and samples on core clock rise.
// (RQ4) Bit period is divide plus one cycles; a divide of 0 gives 2 cycles.
// (RQ5) Low phase: half period, divide/2 if even.
// (RQ6) High phase: half period, divide/2+1 if even.
// (RQ7) Slave modes need sample clock at half core clock.
// (RQ8) Master inverts transmit sync to active-low enable.
// (RQ9) Slave inverts active-low select inputs.
// (RQ10) Master: transmit clock, sync internal; receive external.
// (RQ11) Slave: all clock and sync pins external.
// (RQ12) Enable low before first rise starting transfer.
// (RQ13) Mode 10b: launch on rise, capture on fall.
// (RQ14) Mode 11b: launch on fall, capture on rise.
// (RQ15) Enable lead: low phase in 10b, period in 11b.
// (RQ16) Master releases data after last bit, from a fall.
// (RQ17) Slave releases data when select deasserts.
// (RQ18) Slave drives data soon after select, no clock.
// (RQ19) Bit clock idles except while a word shifts.
module serial_port_spi_clock_stop_mode #(
  parameter int WORD_W     = 16,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                        core_clk_in,  // Core clock
  input  wire logic                        rst_n_in,     // Async reset
  input  wire logic [spi_stop_pkg::ADDR_W-1:0] addr_in,  // Reg address
  input  wire logic [spi_stop_pkg::DATA_W-1:0] wdata_in, // Write data
  input  wire logic                        wr_in,        // Write strobe
  input  wire logic                        rd_in,        // Read strobe
  output logic [spi_stop_pkg::DATA_W-1:0]  rdata_out,    // Read data
  output logic                             tx_ready_out, // FIFO room
  output logic                             busy_out,     // Transfer on
  input  wire logic                        rx_bit_clock_pin_in,
  output logic                             rx_bit_clock_pin_out,
  output logic                             rx_bit_clock_pin_oe,
  input  wire logic                        rx_frame_sync_pin_in,
  output logic                             rx_frame_sync_pin_out,
  output logic                             rx_frame_sync_pin_oe,
  input  wire logic                        tx_bit_clock_pin_in,
  output logic                             tx_bit_clock_pin_out,
  output logic                             tx_bit_clock_pin_oe,
  input  wire logic                        tx_frame_sync_pin_in,
  output logic                             tx_frame_sync_pin_out,
  output logic                             tx_frame_sync_pin_oe,
  input  wire logic                        serial_data_in_pin_in,
  output logic                             serial_data_out_pin_out,
  output logic                             serial_data_out_pin_oe
);
  import spi_stop_pkg::*;

  localparam int BIT_W = $clog2(WORD_W + 1);
  localparam logic [BIT_W-1:0] BITS_ALL  = BIT_W'(WORD_W);
  localparam logic [BIT_W-1:0] BITS_LAST = BIT_W'(WORD_W - 1);

  // ==========================================================
  // Phase lengths in core cycles
  function automatic logic [CNT_W-1:0] low_len(
    input logic [DIV_W-1:0] dv
  );
    logic [CNT_W-1:0] w;
    w = {1'b0, dv};
    if (dv == '0) begin
      low_len = CNT_W'(1);
    end else if (dv[0]) begin
      low_len = (w + 1'b1) >> 1;
    end else begin
      low_len = w >> 1;
    end
  endfunction

  function automatic logic [CNT_W-1:0] high_len(
    input logic [DIV_W-1:0] dv
  );
    logic [CNT_W-1:0] w;
    w = {1'b0, dv};
    if (dv == '0) begin
      high_len = CNT_W'(1);
    end else if (dv[0]) begin
      high_len = (w + 1'b1) >> 1;
    end else begin
      high_len = (w >> 1) + 1'b1;
    end
  endfunction

  // ==========================================================
  // Declarations
  ctrl_t              ctrl;
  logic [DIV_W-1:0]   div;
  logic [NPINS-1:0]   gpio_sel, gpio_dir, gpio_out, pin_raw;
  logic [NPINS-1:0]   sync1, sync2, sync3, clean;
  logic [NPINS-1:0]   func_out, func_oe, pin_out, pin_oe;
  mstate_t            mstate;
  logic [CNT_W-1:0]   cnt, lo_cycles, hi_cycles, lead_cycles;
  logic               clk_int, sel_int, ext_clk, ext_clk_prev;
  logic               sel_act, sel_prev;
  logic [WORD_W-1:0]  sreg, rsh, next_rx, rx_data;
  logic [BIT_W-1:0]   bitcnt;
  logic               den, rx_full, overrun, underrun;
  logic               run, is_master, mode11, m_start, s_start;
  logic               m_rise, m_fall, m_done, rise, fall;
  logic               launch, capture, done_now;
  logic               fifo_wr, fifo_ready, fifo_valid, fifo_pop;
  logic [WORD_W-1:0]  fifo_data;
  status_t            status;

  // ==========================================================
  // Pin input synchronisers, three stages each
  assign pin_raw = {1'b0, tx_frame_sync_pin_in, tx_bit_clock_pin_in,
                    serial_data_in_pin_in, rx_frame_sync_pin_in,
                    rx_bit_clock_pin_in};

  generate
    for (genvar g = 0; g < NPINS; g++) begin : g_sync
      // Stage chain, value accepted once stages two and three agree
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          clean[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            clean[g] <= sync3[g]; // RQ3
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Mode decode
  assign run       = ctrl.enable & ctrl.clock_stop_mode_field[1];
  assign is_master = ctrl.tx_clock_direction; // RQ10
  assign mode11    = ctrl.clock_stop_mode_field[0] ==
                     STOP_LAUNCH_FALL_BIT[0];
  assign lo_cycles = low_len(div); // RQ5
  assign hi_cycles = high_len(div); // RQ6
  assign lead_cycles = mode11 ? (lo_cycles + hi_cycles) : lo_cycles; // RQ15

  // External clock level and active-high select
  assign ext_clk = clean[PIN_XCLK] ^ ctrl.tx_clock_polarity;
  assign sel_act = clean[PIN_XFS] ^ ctrl.tx_sync_polarity;   // RQ9

  // Edge history for slave use
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_clk_prev <= 1'b0;
      sel_prev     <= 1'b0;
    end else begin
      ext_clk_prev <= ext_clk;
      sel_prev     <= sel_act;
    end
  end

  // ==========================================================
  // Start and edge events
  assign m_start = run & is_master & (mstate == M_IDLE) & fifo_valid;
  assign s_start = run & ~is_master & sel_act & ~sel_prev;   // RQ11
  assign fifo_pop = m_start | s_start;
  assign m_done  = (bitcnt == BITS_ALL) & (~den | ~mode11);
  assign m_rise  = ((mstate == M_LEAD) && (cnt == '0)) ||
                   ((mstate == M_SHIFT) && (cnt == '0) &&
                    !clk_int && !m_done);                    // RQ12
  assign m_fall  = (mstate == M_SHIFT) && (cnt == '0) && clk_int;
  assign rise    = is_master ? m_rise
                   : (run & sel_act & ext_clk & ~ext_clk_prev);
  assign fall    = is_master ? m_fall
                   : (run & sel_act & ~ext_clk & ext_clk_prev);
  assign launch  = mode11 ? fall : rise;                     // RQ13 RQ14
  assign capture = mode11 ? rise : fall;                     // RQ13 RQ14
  assign next_rx = {rsh[WORD_W-2:0], clean[PIN_RDAT]};
  assign done_now = capture && (bitcnt == BITS_LAST);

  // ==========================================================
  // Master sequencer: enable lead, clocking, tail
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mstate  <= M_IDLE;
      cnt     <= '0;
      clk_int <= 1'b0;
      sel_int <= 1'b0;
    end else if (!run || !is_master) begin
      mstate  <= M_IDLE;
      clk_int <= 1'b0;                                       // RQ19
      sel_int <= 1'b0;
    end else begin
      unique case (mstate)
        M_IDLE: begin
          clk_int <= 1'b0; // RQ19
          if (m_start) begin
            sel_int <= 1'b1; // RQ12
            cnt     <= lead_cycles - 1'b1; // RQ15
            mstate  <= M_LEAD;
          end
        end
        M_LEAD: begin
          if (cnt == '0) begin
            clk_int <= 1'b1;
            cnt     <= hi_cycles - 1'b1; // RQ6
            mstate  <= M_SHIFT;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        M_SHIFT: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (clk_int) begin
            clk_int <= 1'b0;
            cnt     <= lo_cycles - 1'b1; // RQ5
          end else if (m_done) begin
            cnt    <= lo_cycles + hi_cycles - 1'b1; // RQ4
            mstate <= M_TAIL;
          end else begin
            clk_int <= 1'b1;
            cnt     <= hi_cycles - 1'b1; // RQ4
          end
        end
        M_TAIL: begin
          if (cnt == '0) begin
            sel_int <= 1'b0;
            mstate  <= M_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Shifters and data drive
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sreg   <= '0;
      rsh    <= '0;
      bitcnt <= '0;
      den    <= 1'b0;
    end else if (fifo_pop) begin
      sreg   <= fifo_valid ? fifo_data : '0;
      bitcnt <= '0;
      den    <= mode11 | ~is_master; // RQ18
    end else if (!is_master && (!sel_act || !run)) begin
      den <= 1'b0; // RQ17
    end else begin
      if (launch) begin
        if (bitcnt == BITS_ALL) begin
          if (is_master) begin
            den <= 1'b0; // RQ16
          end
        end else begin
          den <= 1'b1; // RQ13
          if (bitcnt != '0) begin
            sreg <= sreg << 1; // RQ14
          end
        end
      end
      if (capture && (bitcnt != BITS_ALL)) begin
        rsh    <= next_rx;
        bitcnt <= bitcnt + 1'b1;
      end
      // 10b: release one low phase after the last fall
      if (is_master && (mstate == M_SHIFT) && (cnt == '0) &&
          !clk_int && m_done) begin
        den <= 1'b0; // RQ16
      end
    end
  end

  // Received word and sticky flags, set beats clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_data  <= '0;
      rx_full  <= 1'b0;
      overrun  <= 1'b0;
      underrun <= 1'b0;
    end else begin
      if (done_now) begin
        rx_data <= next_rx;
        rx_full <= 1'b1;
      end else if (rd_in && (addr_in == ADDR_RXDATA)) begin
        rx_full <= 1'b0;
      end
      if (done_now && rx_full) begin
        overrun <= 1'b1;
      end else if (rd_in && (addr_in == ADDR_STATUS)) begin
        overrun <= 1'b0;
      end
      if (s_start && !fifo_valid) begin
        underrun <= 1'b1;
      end else if (rd_in && (addr_in == ADDR_STATUS)) begin
        underrun <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Transmit FIFO
  assign fifo_wr = wr_in & (addr_in == ADDR_TXDATA);

  tx_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in       (core_clk_in),
    .rst_n_in     (rst_n_in),
    .wr_valid_in  (fifo_wr),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (wdata_in[WORD_W-1:0]),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_pop),
    .rd_data_out  (fifo_data)
  );

  // ==========================================================
  // Pin functions in serial use
  always_comb begin
    func_out           = '0;
    func_oe            = '0;
    func_out[PIN_RCLK] = clk_int ^ ctrl.rx_clock_polarity;
    func_out[PIN_RFS]  = sel_int ^ ctrl.rx_sync_polarity;
    func_out[PIN_XCLK] = clk_int ^ ctrl.tx_clock_polarity;
    func_out[PIN_XFS]  = sel_int ^ ctrl.tx_sync_polarity;    // RQ8
    func_out[PIN_XDAT] = sreg[WORD_W-1];
    func_oe[PIN_RCLK]  = run & ctrl.rx_clock_direction;
    func_oe[PIN_RFS]   = run & ctrl.rx_sync_direction;
    func_oe[PIN_XCLK]  = run & ctrl.tx_clock_direction;
    func_oe[PIN_XFS]   = run & ctrl.tx_sync_direction;
    func_oe[PIN_XDAT]  = den;
  end

  // Registered pin drive, general I/O overrides serial use
  generate
    for (genvar p = 0; p < NPINS; p++) begin : g_pin
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_out[p] <= 1'b0;
          pin_oe[p]  <= 1'b0;
        end else begin
          pin_out[p] <= gpio_sel[p] ? gpio_out[p] : func_out[p]; // RQ3
          pin_oe[p]  <= OUTPUT_MASK[p] &
                        (gpio_sel[p] ? gpio_dir[p] : func_oe[p]); // RQ2
        end
      end
    end
  endgenerate

  assign rx_bit_clock_pin_out    = pin_out[PIN_RCLK];
  assign rx_bit_clock_pin_oe     = pin_oe[PIN_RCLK];
  assign rx_frame_sync_pin_out   = pin_out[PIN_RFS];
  assign rx_frame_sync_pin_oe    = pin_oe[PIN_RFS];
  assign tx_bit_clock_pin_out    = pin_out[PIN_XCLK];
  assign tx_bit_clock_pin_oe     = pin_oe[PIN_XCLK];
  assign tx_frame_sync_pin_out   = pin_out[PIN_XFS];
  assign tx_frame_sync_pin_oe    = pin_oe[PIN_XFS];
  assign serial_data_out_pin_out = pin_out[PIN_XDAT];
  assign serial_data_out_pin_oe  = pin_oe[PIN_XDAT];

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl     <= CTRL_RESET;
      div      <= DIV_RESET;
      gpio_sel <= PINS_RESET;
      gpio_dir <= PINS_RESET;
      gpio_out <= PINS_RESET;
    end else if (wr_in) begin
      unique case (addr_in)
        ADDR_CTRL:     ctrl     <= wdata_in[$bits(ctrl_t)-1:0];
        ADDR_DIV:      div      <= wdata_in[DIV_W-1:0];
        ADDR_GPIO_SEL: gpio_sel <= wdata_in[NPINS-1:0];
        ADDR_GPIO_DIR: gpio_dir <= wdata_in[NPINS-1:0];
        ADDR_GPIO_OUT: gpio_out <= wdata_in[NPINS-1:0];
        default: begin
        end
      endcase
    end
  end

  // Status view
  assign busy_out     = (mstate != M_IDLE) | (run & ~is_master & sel_act);
  assign tx_ready_out = fifo_ready;
  assign status = '{underrun: underrun, overrun: overrun,
                    tx_empty: ~fifo_valid, tx_ready: fifo_ready,
                    rx_full: rx_full, busy: busy_out};

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        ADDR_CTRL:     rdata_out <= DATA_W'(ctrl);
        ADDR_DIV:      rdata_out <= DATA_W'(div);
        ADDR_RXDATA:   rdata_out <= DATA_W'(rx_data);
        ADDR_STATUS:   rdata_out <= DATA_W'(status);
        ADDR_GPIO_SEL: rdata_out <= DATA_W'(gpio_sel);
        ADDR_GPIO_DIR: rdata_out <= DATA_W'(gpio_dir);
        ADDR_GPIO_OUT: rdata_out <= DATA_W'(gpio_out);
        ADDR_GPIO_IN:  rdata_out <= DATA_W'(clean & INPUT_MASK); // RQ1
        default:       rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

`default_nettype wire

// ---- tb/spi_stop_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pin and bus checks
module spi_stop_checker (
  input wire logic        core_clk_in, rst_n_in, rd_in, wr_in, busy_out,
  input wire logic [15:0] rdata_out,
  input wire logic        rx_bit_clock_pin_out, tx_bit_clock_pin_out,
  input wire logic        tx_frame_sync_pin_out, tx_frame_sync_pin_oe,
  input wire logic        serial_data_out_pin_oe
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_RD_WIN: assert property (
    rdata_out != 16'h0000 |-> $past(rd_in)) else $error("stray read data");
  AST_CLK_IDLE: assert property (
    !busy_out && !$past(busy_out) && !$past(wr_in) && !$past(wr_in, 2)
    |-> $stable(tx_bit_clock_pin_out)) else $error("clock moved idle");
  AST_SEL_FIRST: assert property (
    $fell(tx_frame_sync_pin_out) && busy_out |-> !tx_bit_clock_pin_out)
    else $error("clock high at select");
  AST_SEL_HELD: assert property (
    $fell(tx_frame_sync_pin_out) && busy_out |=> !tx_frame_sync_pin_out [*8])
    else $error("select dropped early");
  AST_CLK_IN_SEL: assert property (
    $changed(tx_bit_clock_pin_out) && busy_out |-> !tx_frame_sync_pin_out)
    else $error("clock moved unselected");
  AST_DOUT_REL: assert property (
    $rose(tx_frame_sync_pin_out) && tx_frame_sync_pin_oe
    |-> !serial_data_out_pin_oe) else $error("data driven after select");
  AST_DOUT_IN_SEL: assert property (
    $rose(serial_data_out_pin_oe) && busy_out && tx_frame_sync_pin_oe
    |-> !tx_frame_sync_pin_out)
    else $error("data driven unselected");
  AST_GPIO_WR: assert property (
    $changed(rx_bit_clock_pin_out) && !busy_out
    |-> $past(wr_in) || $past(wr_in, 2)) else $error("pin moved unasked");
endmodule

bind serial_port_spi_clock_stop_mode spi_stop_checker chk (
  .core_clk_in, .rst_n_in, .rd_in, .wr_in, .rdata_out, .busy_out,
  .rx_bit_clock_pin_out, .tx_bit_clock_pin_out, .tx_frame_sync_pin_out,
  .tx_frame_sync_pin_oe, .serial_data_out_pin_oe);
`default_nettype wire

// ---- tb/spi_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side serial slave device
module spi_slave_model (
  input  wire logic        sclk_in,  // Bit clock
  input  wire logic        sel_n_in, // Active-low enable
  input  wire logic        mosi_in,  // Data from master
  input  wire logic        late_in,  // Capture on rise
  input  wire logic [15:0] reply_in, // Word to return
  output logic             miso_out, // Data to master
  output logic      [15:0] got_out   // Word received
);
  logic [15:0] sh;
  int          n;
  initial miso_out = 1'b0;
  // Load reply, first bit shown at select
  always @(negedge sel_n_in) begin
    sh = reply_in;
    n = 0;
    miso_out = reply_in[15];
  end
  // Released line flips level
  always @(posedge sel_n_in) miso_out = ~miso_out;
  // Capture on one edge, shift on the other
  always @(sclk_in) begin
    if (sel_n_in === 1'b0 && sclk_in == late_in) begin
      got_out = {got_out[14:0], mosi_in};
      n++;
    end else if (sel_n_in === 1'b0 && n > 0) begin
      sh = sh << 1;
      miso_out = sh[15];
    end
  end
endmodule
`default_nettype wire

// ---- tb/serial_port_spi_clock_stop_mode_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_port_spi_clock_stop_mode_tb;
  import spi_stop_pkg::*;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [3:0]  addr_in  = 4'h0;
  logic [15:0] wdata_in = 16'h0000, reply = 16'h0000, rdata_out, got, v;
  logic [4:0]  pin_in   = 5'h00, po, oe;
  logic        gp = 1'b0, late = 1'b0, miso, tx_ready_out, busy_out;
  logic rx_bit_clock_pin_in, rx_bit_clock_pin_out, rx_bit_clock_pin_oe;
  logic rx_frame_sync_pin_in, rx_frame_sync_pin_out, rx_frame_sync_pin_oe;
  logic tx_bit_clock_pin_in, tx_bit_clock_pin_out, tx_bit_clock_pin_oe;
  logic tx_frame_sync_pin_in, tx_frame_sync_pin_out, tx_frame_sync_pin_oe;
  logic serial_data_in_pin_in, serial_data_out_pin_out;
  logic serial_data_out_pin_oe;
  int   fails = 0, n_checks = 0, cyc = 0;
  // ==========================================================
  // Pin wiring
  assign {tx_frame_sync_pin_in, tx_bit_clock_pin_in} = pin_in[4:3];
  assign {rx_frame_sync_pin_in, rx_bit_clock_pin_in} = pin_in[1:0];
  assign serial_data_in_pin_in = gp ? pin_in[2] : miso;
  assign po = {serial_data_out_pin_out, tx_frame_sync_pin_out,
               tx_bit_clock_pin_out, rx_frame_sync_pin_out,
               rx_bit_clock_pin_out};
  assign oe = {serial_data_out_pin_oe, tx_frame_sync_pin_oe,
               tx_bit_clock_pin_oe, rx_frame_sync_pin_oe, rx_bit_clock_pin_oe};
  serial_port_spi_clock_stop_mode uut (.*);
  spi_slave_model peer (
    .sclk_in (tx_bit_clock_pin_oe ? tx_bit_clock_pin_out : 1'b0),
    .sel_n_in(tx_frame_sync_pin_oe ? tx_frame_sync_pin_out : 1'b1),
    .mosi_in (serial_data_out_pin_oe ? serial_data_out_pin_out : 1'bz),
    .late_in (late), .reply_in(reply), .miso_out(miso), .got_out(got));
  // ==========================================================
  // Clock and hang guard
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Bus cycles and reset
  task wr(input logic [3:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in) wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in) rd_in <= 1'b0;
    #1 d = rdata_out;
    @(posedge core_clk_in);
  endtask
  task do_reset();
    rst_n_in <= 1'b0;
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
  endtask
  // ==========================================================
  // Scenarios
  task t_gpio();
    gp <= 1'b1;
    wr(ADDR_GPIO_SEL, 16'h003F);
    wr(ADDR_GPIO_DIR, 16'h003F);
    wr(ADDR_GPIO_OUT, 16'h002B);
    @(posedge core_clk_in);
    #1 check("gpio oe", oe, 5'h1F);
    check("gpio out", po, 5'h17);
    @(posedge core_clk_in);
    wr(ADDR_GPIO_DIR, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      pin_in <= i ? 5'h1A : 5'h15;
      repeat (4) @(posedge core_clk_in);
      rd(ADDR_GPIO_IN, v);
      check("gpio in", v, i ? 16'h001A : 16'h0015);
    end
    wr(ADDR_GPIO_SEL, 16'h0000);
    gp <= 1'b0;
  endtask
  task t_fifo();
    for (int i = 0; i < 5; i++) begin
      check("room", tx_ready_out, i < 4);
      wr(ADDR_TXDATA, 16'h0000);
    end
    rd(ADDR_STATUS, v);
    check("full status", v, 16'h0000);
    do_reset();
    rd(ADDR_STATUS, v);
    check("reset status", v, 16'h000C);
    rd(ADDR_DIV, v);
    check("div reset", v, 16'h0001);
    rd(4'hF, v);
    check("unmapped", v, 16'h0000);
  endtask
  task t_xfer(input logic m11, input logic [7:0] dv,
                        input logic [15:0] tw, rw);
    realtime t0, t1, t2, t3;
    int      lo;
    lo = dv[0] ? (dv + 1) / 2 : dv / 2;
    reply <= rw;
    late <= m11;
    wr(ADDR_DIV, {8'h00, dv});
    wr(ADDR_CTRL, m11 ? 16'h02E7 : 16'h02E5);
    wr(ADDR_TXDATA, tw);
    @(negedge tx_frame_sync_pin_out) t0 = $realtime;
    @(posedge tx_bit_clock_pin_out) t1 = $realtime;
    @(negedge tx_bit_clock_pin_out) t2 = $realtime;
    @(posedge tx_bit_clock_pin_out) t3 = $realtime;
    check("lead", int'((t1 - t0) / 10.0), m11 ? dv + 1 : lo);
    check("high", int'((t2 - t1) / 10.0), dv + 1 - lo);
    check("period", int'((t3 - t1) / 10.0), dv + 1);
    @(posedge tx_frame_sync_pin_out);
    @(posedge core_clk_in);
    check("sent", got, tw);
    rd(ADDR_RXDATA, v);
    check("received", v, rw);
    wr(ADDR_CTRL, 16'h0000);
  endtask
  task t_slave();
    wr(ADDR_DIV, 16'h0001);
    wr(ADDR_CTRL, 16'h0865);
    wr(ADDR_TXDATA, 16'h8000);
    for (int i = 0; i < 2; i++) begin
      pin_in <= i ? 5'h10 : 5'h00;
      repeat (7) @(posedge core_clk_in);
      check("slave oe", serial_data_out_pin_oe, !i);
    end
    wr(ADDR_CTRL, 16'h0000);
  endtask
  initial begin
    do_reset();
    t_gpio();
    t_fifo();
    t_xfer(1'b0, 8'h0B, 16'hA5C3, 16'h3C5A);
    t_xfer(1'b1, 8'h0C, 16'h8001, 16'h7FFE);
    t_slave();
    give_verdict();
  end
endmodule
`default_nettype wire
